// File: memmap_pkg.sv
// Purpose: constants and carriers for the data/code memory map decoder
// Assumes: 16-bit addresses, 4-bit data nibbles, 13-bit code words
// Notes:   every address boundary, the pc reset value and the erased code word are named here once
package memmap_pkg;

  // -------------------------------------------------------------------
  // code space
  // -------------------------------------------------------------------
  localparam logic [15:0] CODE_LO      = 16'h0000;
  localparam logic [15:0] CODE_HI      = 16'h3fff;
  localparam logic [15:0] PC_RESET     = 16'h0110;
  localparam logic [15:0] VEC_NMI      = 16'h0100;
  localparam logic [15:0] VEC_HW_LO    = 16'h0101;
  localparam logic [15:0] VEC_HW_HI    = 16'h010f;
  localparam logic [12:0] CODE_ERASED  = 13'h1fff;
  localparam logic [3:0]  NIB_ERASED   = 4'hf;
  localparam logic [3:0]  NIB_UNDEF    = 4'h0;

  // -------------------------------------------------------------------
  // data space
  // -------------------------------------------------------------------
  localparam logic [15:0] RAM_LO       = 16'h0000;
  localparam logic [15:0] RAM_HI       = 16'h07ff;
  localparam logic [15:0] WIDE_LO      = 16'h0100;
  localparam logic [15:0] WIDE_HI      = 16'h01ff;
  localparam logic [15:0] DROM_LO      = 16'h8000;
  localparam logic [15:0] DROM_HI      = 16'h8fff;
  localparam logic [15:0] DISP_LO      = 16'hf000;
  localparam logic [15:0] DISP_HI      = 16'hf07f;
  localparam logic [15:0] IO_LO        = 16'hff00;
  localparam logic [15:0] IO_HI        = 16'hffff;
  localparam logic [15:0] IO_OSC       = 16'hff00;
  localparam logic [15:0] IO_WDT       = 16'hff01;
  localparam logic [15:0] IO_CLK_LO    = 16'hff10;
  localparam logic [15:0] IO_CLK_HI    = 16'hff1b;
  localparam logic [15:0] IO_PORT_LO   = 16'hff20;
  localparam logic [15:0] IO_PORT_HI   = 16'hff3f;
  localparam logic [15:0] IO_TMR_LO    = 16'hff80;
  localparam logic [15:0] IO_TMR_HI    = 16'hff9f;
  localparam logic [15:0] IO_INT_LO    = 16'hffe1;
  localparam logic [15:0] IO_INT_HI    = 16'hffff;

  // stack pointer wrap masks and push step sizes
  localparam logic [15:0] WSP_MASK     = 16'h1fff;
  localparam logic [15:0] NSP_MASK     = 16'h00ff;
  localparam logic [2:0]  CALL_WORDS   = 3'h4;
  localparam logic [2:0]  FLAG_WORDS   = 3'h1;

  // selected target of a data access
  typedef enum logic [2:0] {
    SEL_NONE, SEL_RAM, SEL_DROM, SEL_DISP, SEL_IO
  } region_t;

  // peripheral group in the I/O window
  typedef enum logic [2:0] {
    IOG_NONE, IOG_OSC, IOG_WDT, IOG_CLK, IOG_PORT, IOG_TMR, IOG_INT
  } io_group_t;

  // data bus request from the core
  typedef struct packed {
    logic        req;
    logic        we;
    logic        wide;    // 16-bit access
    logic        stack;   // issued through the wide stack pointer
    logic [15:0] addr;
    logic [15:0] wdata;
  } data_req_t;

  // stack pointer write / step requests from the core
  typedef struct packed {
    logic        wsp_we;
    logic        nsp_we;
    logic [15:0] wsp_wdata;
    logic [15:0] nsp_wdata;
    logic        call;    // subroutine call push
    logic        irq_ent; // interrupt entry push
  } stack_req_t;

endpackage

// File: memory_map_decoder.sv
// Purpose: memory map decode, stack pointer tracking and interrupt gate
// Assumes: core issues one data request per cycle; ram internal, code and data roms answer through input ports
// Notes:   read data returns one cycle after the request is taken
`timescale 1ns/1ps

// Notes on behaviour
// - program fetches are valid only from 0000h to 3fffh
// - after reset the program counter starts at 0110h
// - nmi vectors to 0100h, hardware interrupts to 0101h..010fh
// - erased code and data rom bits read as one
// - 2048-nibble ram decoded at 0000h..07ffh
// - 16-bit access allowed only at 0100h..01ffh, elsewhere 4-bit only
// - only stack operations through the wide pointer may be 16-bit
// - wide pointer wraps in 0000h..1fffh, nibble pointer in 0000h..00ffh
// - after reset all interrupts blocked until both pointers written
// - rewriting one pointer masks interrupts until the other is rewritten
// - a call pushes the program counter as four words on the wide stack
// - interrupt entry pushes four wide words and one flag nibble
// - 4096-nibble data rom at 8000h..8fffh, read like ram
// - display ram at f000h..f07fh, bits mapped to segments by assignment
// - unassigned display locations act as ordinary storage
// - peripheral registers mapped from ff00h to ffffh in fixed groups
module memory_map_decoder
  import memmap_pkg::*;
#(
  parameter int RAM_WORDS  = 2048,
  parameter int DROM_WORDS = 4096,
  parameter int DISP_WORDS = 128,
  parameter int SEG_COUNT  = 56
)(
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic                    fetch_req,
  input  wire logic [15:0]             fetch_addr,
  input  wire logic                    vec_take,
  input  wire logic                    vec_nmi,
  input  wire logic [3:0]              vec_hw_idx,
  input  wire data_req_t               dreq,
  input  wire stack_req_t              sreq,
  input  wire logic [12:0]             code_rom_data,
  input  wire logic [3:0]              drom_data,
  input  wire logic [3:0]              io_rdata,
  input  wire logic [SEG_COUNT*9-1:0]  seg_assign,
  output logic [15:0]                  code_rom_addr,
  output logic [12:0]                  fetch_data_r,
  output logic [15:0]                  program_counter_r,
  output logic [11:0]                  drom_addr,
  output logic [15:0]                  rdata_r,
  output logic                         access_err_r,
  output io_group_t                    io_group,
  output logic                         io_sel,
  output logic [7:0]                   io_addr,
  output logic [15:0]                  wide_stack_pointer_r,
  output logic [15:0]                  nibble_stack_pointer_r,
  output logic                         irq_enable,
  output logic [SEG_COUNT-1:0]         seg_out_r
);

  // -------------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------------
  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  function automatic region_t decode(input logic [15:0] a);
    if (in_rng(a, RAM_LO, RAM_HI))        decode = SEL_RAM;
    else if (in_rng(a, DROM_LO, DROM_HI)) decode = SEL_DROM;
    else if (in_rng(a, DISP_LO, DISP_HI)) decode = SEL_DISP;
    else if (in_rng(a, IO_LO, IO_HI))     decode = SEL_IO;
    else                                  decode = SEL_NONE;
  endfunction

  // -------------------------------------------------------------------
  // program fetch and counter
  // -------------------------------------------------------------------
  logic fetch_ok;
  assign fetch_ok      = in_rng(fetch_addr, CODE_LO, CODE_HI);
  assign code_rom_addr = fetch_addr;

  // out-of-range fetches see erased code rather than aliasing low memory
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      fetch_data_r <= CODE_ERASED;
    else if (fetch_req)
      fetch_data_r <= fetch_ok ? code_rom_data : CODE_ERASED;
  end

  // counter: reset start, vector jumps, otherwise follows fetches
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      program_counter_r <= PC_RESET;
    else if (vec_take && irq_enable)
    begin
      if (vec_nmi)
        program_counter_r <= VEC_NMI;
      else if (vec_hw_idx != 4'h0)
        program_counter_r <= VEC_NMI + {12'h000, vec_hw_idx};
    end
    else if (fetch_req)
      program_counter_r <= fetch_addr + 16'h0001;
  end

  // -------------------------------------------------------------------
  // data access decode and width check
  // -------------------------------------------------------------------
  region_t     sel;
  logic        wide_ok;
  logic        acc_ok;
  logic [15:0] a;
  assign a       = dreq.addr;
  assign sel     = decode(a);
  // wide access needs a stack op and the dual-width window
  assign wide_ok = dreq.stack && in_rng(a, WIDE_LO, WIDE_HI);
  assign acc_ok  = dreq.req && (sel != SEL_NONE) && (!dreq.wide || wide_ok);

  assign drom_addr = a[11:0];
  assign io_addr   = a[7:0];
  assign io_sel    = acc_ok && (sel == SEL_IO);

  // peripheral group decode; unmapped holes inside the window give none
  always_comb
  begin
    io_group = IOG_NONE;
    if (sel == SEL_IO)
    begin
      if (a == IO_OSC)                          io_group = IOG_OSC;
      else if (a == IO_WDT)                     io_group = IOG_WDT;
      else if (in_rng(a, IO_CLK_LO, IO_CLK_HI))   io_group = IOG_CLK;
      else if (in_rng(a, IO_PORT_LO, IO_PORT_HI)) io_group = IOG_PORT;
      else if (in_rng(a, IO_TMR_LO, IO_TMR_HI))   io_group = IOG_TMR;
      else if (in_rng(a, IO_INT_LO, IO_INT_HI))   io_group = IOG_INT;
    end
  end

  // -------------------------------------------------------------------
  // ram and display storage
  // -------------------------------------------------------------------
  logic [3:0] ram_r  [RAM_WORDS];
  logic [3:0] disp_r [DISP_WORDS];
  logic [10:0] ram_idx;
  logic [6:0]  disp_idx;
  assign ram_idx  = a[10:0];
  assign disp_idx = a[6:0];

  // wide writes fill four consecutive nibbles, low nibble at the address
  always_ff @(posedge sys_clk)
  begin
    if (acc_ok && dreq.we && sel == SEL_RAM)
    begin
      if (dreq.wide)
      begin
        for (int i = 0; i < 4; i++)
          ram_r[ram_idx + 11'(i)] <= dreq.wdata[4*i +: 4];
      end
      else
        ram_r[ram_idx] <= dreq.wdata[3:0];
    end
  end

  // every display nibble is plain storage; segments only read it
  always_ff @(posedge sys_clk)
  begin
    if (acc_ok && dreq.we && sel == SEL_DISP)
      disp_r[disp_idx] <= dreq.wdata[3:0];
  end

  // read mux; rom region reads the flash nibble, holes read filler
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata_r <= 16'h0000;
    else if (dreq.req && !dreq.we)
    begin
      rdata_r <= {12'h000, NIB_UNDEF};
      if (acc_ok)
      begin
        unique case (sel)
          SEL_RAM:
            if (dreq.wide)
              rdata_r <= {ram_r[ram_idx + 11'h003], ram_r[ram_idx + 11'h002],
                          ram_r[ram_idx + 11'h001], ram_r[ram_idx]};
            else
              rdata_r <= {12'h000, ram_r[ram_idx]};
          SEL_DROM: rdata_r <= {12'h000, drom_data};
          SEL_DISP: rdata_r <= {12'h000, disp_r[disp_idx]};
          SEL_IO:   rdata_r <= {12'h000, io_rdata};
          SEL_NONE: rdata_r <= {12'h000, NIB_UNDEF};
        endcase
      end
    end
  end

  // flag for debug only: a bad access never traps the core
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      access_err_r <= 1'b0;
    else
      access_err_r <= dreq.req && !acc_ok;
  end

  // -------------------------------------------------------------------
  // segment mapping: each segment picks one display bit by index
  // -------------------------------------------------------------------
  generate
    for (genvar s = 0; s < SEG_COUNT; s++)
    begin : g_seg
      logic [8:0] pick;
      assign pick = seg_assign[9*s +: 9];
      always_ff @(posedge sys_clk)
      begin
        if (rst)
          seg_out_r[s] <= 1'b0;
        else
          seg_out_r[s] <= disp_r[pick[8:2]][pick[1:0]];
      end
    end
  endgenerate

  // -------------------------------------------------------------------
  // stack pointers
  // -------------------------------------------------------------------
  logic [15:0] wsp_nxt;
  logic [15:0] nsp_nxt;

  // pushes pre-decrement; masking keeps the wrap inside each range
  always_comb
  begin
    wsp_nxt = wide_stack_pointer_r;
    nsp_nxt = nibble_stack_pointer_r;
    if (sreq.wsp_we)
      wsp_nxt = sreq.wsp_wdata & WSP_MASK;
    else if (sreq.call || sreq.irq_ent)
      wsp_nxt = (wide_stack_pointer_r - {13'h0000, CALL_WORDS}) & WSP_MASK;
    if (sreq.nsp_we)
      nsp_nxt = sreq.nsp_wdata & NSP_MASK;
    else if (sreq.irq_ent)
      nsp_nxt = (nibble_stack_pointer_r - {13'h0000, FLAG_WORDS}) & NSP_MASK;
  end

  // pointer contents are undefined after reset; cleared for determinism
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wide_stack_pointer_r   <= 16'h0000;
      nibble_stack_pointer_r <= 16'h0000;
    end
    else
    begin
      wide_stack_pointer_r   <= wsp_nxt;
      nibble_stack_pointer_r <= nsp_nxt;
    end
  end

  // -------------------------------------------------------------------
  // interrupt gate: open only once both pointers have a fresh write
  // -------------------------------------------------------------------
  logic wsp_set_r;
  logic nsp_set_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      wsp_set_r <= 1'b0;
      nsp_set_r <= 1'b0;
    end
    else if (sreq.wsp_we && sreq.nsp_we)
    begin
      wsp_set_r <= 1'b1;
      nsp_set_r <= 1'b1;
    end
    else if (sreq.wsp_we)
    begin
      // a lone rewrite after both were set re-arms the mask
      wsp_set_r <= 1'b1;
      if (wsp_set_r && nsp_set_r)
        nsp_set_r <= 1'b0;
    end
    else if (sreq.nsp_we)
    begin
      nsp_set_r <= 1'b1;
      if (wsp_set_r && nsp_set_r)
        wsp_set_r <= 1'b0;
    end
  end

  assign irq_enable = wsp_set_r && nsp_set_r;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  pc_reset_a: assert property (@(posedge sys_clk) $fell(rst) |->
    program_counter_r == PC_RESET) else $error("pc not at start after reset");
  nmi_vec_a: assert property (@(posedge sys_clk) disable iff (rst)
    vec_take && irq_enable && vec_nmi |=> program_counter_r == VEC_NMI)
    else $error("nmi vector wrong");
  fetch_range_a: assert property (@(posedge sys_clk) disable iff (rst)
    fetch_req && !in_rng(fetch_addr, CODE_LO, CODE_HI) |=> fetch_data_r == CODE_ERASED)
    else $error("fetch beyond code space not erased");
  wide_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    dreq.req && dreq.wide && !(dreq.stack && in_rng(a, WIDE_LO, WIDE_HI)) |=> access_err_r)
    else $error("illegal wide access accepted");
  wsp_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    wide_stack_pointer_r <= WSP_MASK) else $error("wide pointer out of range");
  nsp_wrap_a: assert property (@(posedge sys_clk) disable iff (rst)
    nibble_stack_pointer_r <= NSP_MASK) else $error("nibble pointer out of range");
  call_push_a: assert property (@(posedge sys_clk) disable iff (rst)
    sreq.call && !sreq.wsp_we |=> wide_stack_pointer_r ==
    (($past(wide_stack_pointer_r) - 16'h0004) & WSP_MASK))
    else $error("call push not four words");
  irq_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    sreq.irq_ent && !sreq.nsp_we |=> nibble_stack_pointer_r ==
    (($past(nibble_stack_pointer_r) - 16'h0001) & NSP_MASK))
    else $error("flag push not one word");
  mask_reset_a: assert property (@(posedge sys_clk) $fell(rst) |->
    !irq_enable) else $error("interrupts open after reset");
  remask_a: assert property (@(posedge sys_clk) disable iff (rst)
    irq_enable && (sreq.wsp_we ^ sreq.nsp_we) |=> !irq_enable)
    else $error("lone pointer rewrite left interrupts open");

  irq_open_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(irq_enable));
  wide_rd_c:  cover property (@(posedge sys_clk) disable iff (rst)
    dreq.req && dreq.wide && !dreq.we && acc_ok);
  drom_rd_c:  cover property (@(posedge sys_clk) disable iff (rst)
    acc_ok && sel == SEL_DROM);

endmodule

// File: flash_io_model.sv
// Purpose: behavioural stand-in for code flash, data flash and peripheral read mux
// Assumes: all three answer combinationally from the address the decoder presents
// Notes:   contents are a fixed pattern so the bench can work out every expected word
`timescale 1ns/1ps
module flash_io_model
  import memmap_pkg::*;
(
  input  wire logic [15:0] code_rom_addr,
  input  wire logic [11:0] drom_addr,
  input  wire logic [7:0]  io_addr,
  output logic      [12:0] code_rom_data,
  output logic      [3:0]  drom_data,
  output logic      [3:0]  io_rdata
);
  // ---------------------------------------------------------------
  // code flash: 13-bit words, programmed with the low 13 address bits xor 0aaah
  // ---------------------------------------------------------------
  // cells decode only the low 13 address bits, so steps beyond 1fffh alias onto
  // low words; the decoder hides only those beyond 3fffh behind the erased value
  assign code_rom_data = code_rom_addr[12:0] ^ 13'h0aaa;
  // ---------------------------------------------------------------
  // data flash and peripheral read data
  // ---------------------------------------------------------------
  // xor pattern on the low four address bits so a dropped bit 0..3 shows up as a wrong nibble
  assign drom_data = drom_addr[3:0] ^ 4'h5;
  assign io_rdata  = io_addr[3:0];
endmodule

// File: test_memory_map_decoder.sv
// Purpose: self-checking bench for the memory map decoder
// Assumes: inputs change 1 ns after the rising edge; registered answers are one cycle later, io_sel and io_group in the same cycle
// Notes:   seg_assign starts at zero, so every segment follows display word 0 bit 0
`timescale 1ns/1ps
module test_memory_map_decoder;
  import memmap_pkg::*;
  logic             sys_clk = 1'b0;
  logic             rst = 1'b1;
  logic             fetch_req = 1'b0;
  logic      [15:0] fetch_addr = 16'h0000;
  logic             vec_take = 1'b0;
  logic             vec_nmi = 1'b0;
  logic      [3:0]  vec_hw_idx = 4'h0;
  data_req_t        dreq = '0;
  stack_req_t       sreq = '0;
  logic      [503:0] seg_assign = '0;
  logic      [12:0] code_rom_data;
  logic      [3:0]  drom_data;
  logic      [3:0]  io_rdata;
  logic      [15:0] code_rom_addr;
  logic      [12:0] fetch_data_r;
  logic      [15:0] program_counter_r;
  logic      [11:0] drom_addr;
  logic      [15:0] rdata_r;
  logic             access_err_r;
  io_group_t        io_group;
  logic             io_sel;
  logic      [7:0]  io_addr;
  logic      [15:0] wide_stack_pointer_r;
  logic      [15:0] nibble_stack_pointer_r;
  logic             irq_enable;
  logic      [55:0] seg_out_r;
  int               mismatches = 0;
  int               comparisons = 0;

  always #2 sys_clk = ~sys_clk;

  memory_map_decoder i_dut (.sys_clk(sys_clk), .rst(rst), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .vec_take(vec_take), .vec_nmi(vec_nmi),
    .vec_hw_idx(vec_hw_idx), .dreq(dreq), .sreq(sreq), .code_rom_data(code_rom_data),
    .drom_data(drom_data), .io_rdata(io_rdata), .seg_assign(seg_assign),
    .code_rom_addr(code_rom_addr), .fetch_data_r(fetch_data_r),
    .program_counter_r(program_counter_r), .drom_addr(drom_addr), .rdata_r(rdata_r),
    .access_err_r(access_err_r), .io_group(io_group), .io_sel(io_sel),
    .io_addr(io_addr), .wide_stack_pointer_r(wide_stack_pointer_r),
    .nibble_stack_pointer_r(nibble_stack_pointer_r), .irq_enable(irq_enable),
    .seg_out_r(seg_out_r));

  flash_io_model i_flash (.code_rom_addr(code_rom_addr), .drom_addr(drom_addr),
    .io_addr(io_addr), .code_rom_data(code_rom_data), .drom_data(drom_data),
    .io_rdata(io_rdata));

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  task automatic cyc();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one data request, taken at the next edge; result checked by caller
  // req stays up so back-to-back calls never reassign it in one step; idle() drops it
  // holes are touched only to check the error flag and their filler; other traffic keeps to mapped space
  task automatic acc(input logic we, wide, stk, input logic [15:0] a, d);
    dreq = '{req: 1'b1, we: we, wide: wide, stack: stk, addr: a, wdata: d};
    cyc();
  endtask

  // pointer request held like acc; the next stk or idle() replaces it
  task automatic stk(input logic ww, nw, input logic [15:0] wd, nd, input logic c, ie);
    sreq = '{wsp_we: ww, nsp_we: nw, wsp_wdata: wd, nsp_wdata: nd, call: c, irq_ent: ie};
    cyc();
  endtask

  // drop both request strobes and let one edge pass with the buses quiet
  task automatic idle();
    dreq.req = 1'b0;
    sreq = '0;
    cyc();
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    chk("pc", program_counter_r, PC_RESET);
    chk("irq", {15'h0, irq_enable}, 16'h0000);
    chk("fetch_rst", {3'h0, fetch_data_r}, {3'h0, CODE_ERASED});
    chk("rdata_rst", rdata_r, 16'h0000);
    chk("wsp_rst", wide_stack_pointer_r, 16'h0000);
    chk("nsp_rst", nibble_stack_pointer_r, 16'h0000);
    // masked vector request must leave the start address alone
    vec_take = 1'b1;
    vec_nmi = 1'b1;
    cyc();
    vec_take = 1'b0;
    chk("pc_masked", program_counter_r, PC_RESET);
  endtask

  task automatic t_fetch();
    fetch_req = 1'b1;
    fetch_addr = 16'h3fff;
    cyc();
    chk("fetch_top", {3'h0, fetch_data_r}, 16'h1555);
    chk("pc_inc", program_counter_r, 16'h4000);
    fetch_addr = 16'h0123;
    cyc();
    chk("fetch_in", {3'h0, fetch_data_r}, 16'h0b89);
    fetch_addr = 16'h4000;
    cyc();
    fetch_req = 1'b0;
    chk("fetch_out", {3'h0, fetch_data_r}, 16'h1fff);
  endtask

  task automatic t_ram();
    acc(1'b1, 1'b0, 1'b0, 16'h0000, 16'h000c);
    acc(1'b1, 1'b0, 1'b0, 16'h07ff, 16'h000a);
    chk("err_w", {15'h0, access_err_r}, 16'h0000);
    acc(1'b0, 1'b0, 1'b0, 16'h07ff, 16'h0000);
    chk("ram_top", rdata_r, 16'h000a);
    acc(1'b1, 1'b0, 1'b0, 16'h0800, 16'h0003);
    chk("hole_werr", {15'h0, access_err_r}, 16'h0001);
    acc(1'b0, 1'b0, 1'b0, 16'h0800, 16'h0000);
    chk("hole_r", rdata_r, {12'h0, NIB_UNDEF});
    idle();
    chk("err_one", {15'h0, access_err_r}, 16'h0000);
    // a hole write that aliased onto ram would have landed in word 0
    acc(1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000);
    chk("ram_kept", rdata_r, 16'h000c);
  endtask

  task automatic t_wide();
    acc(1'b1, 1'b1, 1'b1, 16'h0100, 16'h4321);
    chk("wide_werr", {15'h0, access_err_r}, 16'h0000);
    acc(1'b0, 1'b0, 1'b0, 16'h0101, 16'h0000);
    chk("wide_nib1", rdata_r, 16'h0002);
    acc(1'b0, 1'b1, 1'b1, 16'h0100, 16'h0000);
    chk("wide_rd", rdata_r, 16'h4321);
    acc(1'b0, 1'b1, 1'b0, 16'h0100, 16'h0000);
    chk("wide_nostk", {15'h0, access_err_r}, 16'h0001);
    chk("wide_nostk_r", rdata_r, 16'h0000);
    acc(1'b1, 1'b0, 1'b0, 16'h0200, 16'h0005);
    acc(1'b1, 1'b1, 1'b1, 16'h0200, 16'hffff);
    chk("wide_out", {15'h0, access_err_r}, 16'h0001);
    acc(1'b0, 1'b0, 1'b0, 16'h0200, 16'h0000);
    chk("wide_drop", {15'h0, access_err_r}, 16'h0000);
    chk("wide_keep", rdata_r, 16'h0005);
  endtask

  task automatic t_regions();
    logic [15:0] a [6];
    io_group_t   g [6];
    int          n;
    a = '{16'hff00, 16'hff01, 16'hff10, 16'hff3f, 16'hff9f, 16'hffe1};
    g = '{IOG_OSC, IOG_WDT, IOG_CLK, IOG_PORT, IOG_TMR, IOG_INT};
    acc(1'b0, 1'b0, 1'b0, 16'h8abc, 16'h0000);
    chk("drom", rdata_r, 16'h0009);
    acc(1'b1, 1'b0, 1'b0, 16'hf07f, 16'h0006);
    acc(1'b0, 1'b0, 1'b0, 16'hf07f, 16'h0000);
    chk("disp_gp", rdata_r, 16'h0006);
    for (n = 0; n < 6; n++)
    begin
      dreq = '{req: 1'b1, we: 1'b0, wide: 1'b0, stack: 1'b0, addr: a[n], wdata: 16'h0};
      #1;
      chk("io_sel", {15'h0, io_sel}, 16'h0001);
      chk("io_grp", {13'h0, io_group}, {13'h0, g[n]});
      cyc();
    end
    // the model answers with the low address nibble of ffe1h
    chk("io_rd", rdata_r, 16'h0001);
    idle();
  endtask

  task automatic t_segment();
    // segment 1 picks display word 7fh bit 0, the rest keep word 0 bit 0
    seg_assign[17:9] = 9'h1fc;
    acc(1'b1, 1'b0, 1'b0, 16'hf000, 16'h0001);
    idle();
    chk("seg0", {15'h0, seg_out_r[0]}, 16'h0001);
    chk("seg1", {15'h0, seg_out_r[1]}, 16'h0000);
    chk("seg55", {15'h0, seg_out_r[55]}, 16'h0001);
  endtask

  task automatic t_stack();
    stk(1'b0, 1'b1, 16'h0, 16'h0000, 1'b0, 1'b0);
    idle();
    chk("irq_half", {15'h0, irq_enable}, 16'h0000);
    stk(1'b1, 1'b0, 16'h0002, 16'h0, 1'b0, 1'b0);
    idle();
    chk("irq_both", {15'h0, irq_enable}, 16'h0001);
    stk(1'b0, 1'b0, 16'h0, 16'h0, 1'b1, 1'b0);
    chk("wsp_call", wide_stack_pointer_r, 16'h1ffe);
    stk(1'b0, 1'b0, 16'h0, 16'h0, 1'b0, 1'b1);
    chk("wsp_int", wide_stack_pointer_r, 16'h1ffa);
    chk("nsp_int", nibble_stack_pointer_r, 16'h00ff);
    stk(1'b1, 1'b0, 16'hffff, 16'h0, 1'b0, 1'b0);
    idle();
    chk("wsp_mask", wide_stack_pointer_r, 16'h1fff);
    chk("irq_lone", {15'h0, irq_enable}, 16'h0000);
    stk(1'b0, 1'b1, 16'h0, 16'h1234, 1'b0, 1'b0);
    idle();
    chk("nsp_mask", nibble_stack_pointer_r, 16'h0034);
    chk("irq_pair", {15'h0, irq_enable}, 16'h0001);
  endtask

  task automatic t_vector();
    vec_take = 1'b1;
    vec_nmi = 1'b1;
    vec_hw_idx = 4'h5;
    cyc();
    chk("vec_nmi", program_counter_r, VEC_NMI);
    vec_nmi = 1'b0;
    vec_hw_idx = 4'hf;
    cyc();
    chk("vec_hwf", program_counter_r, VEC_HW_HI);
    vec_hw_idx = 4'h1;
    cyc();
    vec_take = 1'b0;
    chk("vec_hw1", program_counter_r, VEC_HW_LO);
  endtask

  // ---------------------------------------------------------------
  // verdict and main sequence
  // ---------------------------------------------------------------
  task automatic final_report();
    if (mismatches == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (16) cyc();
    rst = 1'b0;
    t_reset();
    t_fetch();
    t_ram();
    t_wide();
    t_regions();
    t_segment();
    t_stack();
    t_vector();
    final_report();
  end
endmodule
